/* File: logic/flash_sector_protection_defs.svh */
// Purpose: constants for the sector protection logic
// Assumes: 24-bit decoded address, 8-bit registers
// Notes: each offset kept as printed
`ifndef FLASH_SECTOR_PROTECTION_DEFS_SVH
`define FLASH_SECTOR_PROTECTION_DEFS_SVH
// ----------------------------------------
// Register field layout
// ----------------------------------------
`define LOCK_WR_BIT 0
`define LOCK_DN_BIT 1
`define LOCK_RD_BIT 2
`define LOCK_RESET 8'h01
`define LOCK_FIELD_MASK 8'h07
`define READ_LOCKED_DATA 8'h00
// ----------------------------------------
// Hub mode register addresses (A22 low)
// ----------------------------------------
`define REG_HUB_S0 32'hFFBC0002
`define REG_HUB_S1 32'hFFBD0002
`define REG_HUB_S2 32'hFFBE0002
`define REG_HUB_S3 32'hFFBF0002
`define REG_HUB_S4 32'hFFBF8002
`define REG_HUB_S5 32'hFFBFA002
`define REG_HUB_S6 32'hFFBFC002
// Low-pin-count mode differs from hub mode in A23 and A22
`define REG_LPC_XOR 32'h00C00000
// ----------------------------------------
// Sector base addresses
// ----------------------------------------
`define SEC6_BASE 24'h03C000
`define SEC5_BASE 24'h03A000
`define SEC4_BASE 24'h038000
`define SEC3_BASE 24'h030000
`define SEC2_BASE 24'h020000
`define SEC1_BASE 24'h010000
`define ARRAY_MASK 24'h03FFFF
// ----------------------------------------
// Command codes
// ----------------------------------------
`define CMD_PROG_A 8'h40
`define CMD_PROG_B 8'h10
`define CMD_SEC_ERASE 8'h21
`define CMD_UNI_ERASE 8'h20
`endif

/* File: logic/flash_sector_protection_pkg.sv */
// Purpose: types for the sector protection logic
// Assumes: nothing
// Notes: none
package flash_sector_protection_pkg;
   typedef logic [2:0] sector_t;
   typedef enum logic [1:0] {OP_NONE, OP_PROG, OP_SEC_ERASE, OP_UNI_ERASE} op_kind_t;
   typedef enum {ST_IDLE, ST_BUSY} op_state_t;
endpackage

/* File: logic/flash_sector_protection.sv */
// Purpose: per-sector lock registers and program/erase/read gating
// Assumes: host bus framing decoded upstream into one-cycle strobes
// Notes: one clock, synchronous reset
//
// Function
// - Top guard low blocks program/erase of sector 6
// - Top guard low blocks uniform erase of 6-3
// - Top guard high leaves register locks in charge
// - Write guard low blocks program/erase of 5-0
// - Uniform erase: write guard covers only 2-0
// - Fixed address-to-sector map; program codes 40H,10H
// - Guard pins sampled once at operation start
// - Guard pins block despite cleared write lock
// - Guard pins never change or show in registers
// - Read lock settable while guard protects sector
// - Registers at two addresses, by mode bit
// - Registers readable and writable, three lock bits
// - Reset loads 01H into every register
// - Read-locked sector returns 00H, no status flag
// - Lock bits change only when not locked down
// - Write-locked target refused, sector-lock error flagged
// - Write lock sampled at operation start
// - Register read returns current lock bits
// - Bit 2 read, bit 1 down, bit 0 write lock
// - Lock-down set once, then writes ignored
`include "flash_sector_protection_defs.svh"

module flash_sector_protection
   import flash_sector_protection_pkg::*;
#(
   parameter int NUM_SECTORS = 7
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic top_boot_guard_n,
   input wire logic write_guard_n,
   input wire logic hub_mode,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   input wire logic op_start,
   input wire logic [7:0] op_cmd,
   input wire logic [23:0] op_addr,
   input wire logic op_done,
   output logic op_allow,
   output logic op_refused,
   output logic lock_error,
   output logic op_busy,
   input wire logic arr_rd,
   input wire logic [23:0] arr_addr,
   input wire logic [7:0] arr_data,
   output logic [7:0] rd_data
);

   // The address map and uniform erase groups are fixed for seven sectors
   if (NUM_SECTORS != 7) begin
      $error("Sector map fixed at seven sectors");
   end

   // ----------------------------------------
   // Decode functions
   // ----------------------------------------
   function automatic sector_t addr_to_sector(input logic [23:0] a);
      logic [23:0] m;
      m = a & `ARRAY_MASK;
      if (m >= `SEC6_BASE) begin
         addr_to_sector = 3'd6;
      end else if (m >= `SEC5_BASE) begin
         addr_to_sector = 3'd5;
      end else if (m >= `SEC4_BASE) begin
         addr_to_sector = 3'd4;
      end else if (m >= `SEC3_BASE) begin
         addr_to_sector = 3'd3;
      end else if (m >= `SEC2_BASE) begin
         addr_to_sector = 3'd2;
      end else if (m >= `SEC1_BASE) begin
         addr_to_sector = 3'd1;
      end else begin
         addr_to_sector = 3'd0;
      end
   endfunction

   function automatic op_kind_t cmd_kind(input logic [7:0] c);
      if (c == `CMD_PROG_A || c == `CMD_PROG_B) begin
         cmd_kind = OP_PROG;
      end else if (c == `CMD_SEC_ERASE) begin
         cmd_kind = OP_SEC_ERASE;
      end else if (c == `CMD_UNI_ERASE) begin
         cmd_kind = OP_UNI_ERASE;
      end else begin
         cmd_kind = OP_NONE;
      end
   endfunction

   // ----------------------------------------
   // Register address decode
   // ----------------------------------------
   logic [31:0] hub_addr;
   logic [NUM_SECTORS-1:0] reg_sel;
   logic [31:0] reg_map [NUM_SECTORS];

   assign reg_map[0] = `REG_HUB_S0;
   assign reg_map[1] = `REG_HUB_S1;
   assign reg_map[2] = `REG_HUB_S2;
   assign reg_map[3] = `REG_HUB_S3;
   assign reg_map[4] = `REG_HUB_S4;
   assign reg_map[5] = `REG_HUB_S5;
   assign reg_map[6] = `REG_HUB_S6;
   // Low-pin-count addresses are folded onto the hub set
   assign hub_addr = hub_mode ? reg_addr : (reg_addr ^ `REG_LPC_XOR);

   always_comb begin
      for (int i = 0; i < NUM_SECTORS; i++) begin
         reg_sel[i] = (hub_addr == reg_map[i]);
      end
   end
   assign reg_hit = |reg_sel;

   // ----------------------------------------
   // Locking registers
   // ----------------------------------------
   logic [2:0] lock_q [NUM_SECTORS];

   // Guard pins are not an input here, so they cannot alter the bits
   always_ff @(posedge clk) begin
      for (int i = 0; i < NUM_SECTORS; i++) begin
         if (sys_rst) begin
            lock_q[i] <= 3'(`LOCK_RESET);
         end else if (reg_wr && reg_sel[i] && !lock_q[i][`LOCK_DN_BIT]) begin
            lock_q[i] <= reg_wdata[2:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= 8'h00;
         for (int i = 0; i < NUM_SECTORS; i++) begin
            if (reg_sel[i]) begin
               reg_rdata <= {5'h00, lock_q[i]};
            end
         end
      end
   end

   // ----------------------------------------
   // Array read gating
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_data <= 8'h00;
      end else if (arr_rd) begin
         if (lock_q[addr_to_sector(arr_addr)][`LOCK_RD_BIT]) begin
            rd_data <= `READ_LOCKED_DATA;
         end else begin
            rd_data <= arr_data;
         end
      end
   end

   // ----------------------------------------
   // Program and erase gating
   // ----------------------------------------
   op_state_t state_q;
   op_kind_t kind;
   sector_t sec;
   logic hw_block;
   logic sw_block;
   logic [NUM_SECTORS-1:0] uni_set;

   assign kind = cmd_kind(op_cmd);
   assign sec = addr_to_sector(op_addr);

   always_comb begin
      hw_block = 1'b0;
      sw_block = 1'b0;
      uni_set = '0;
      if (kind == OP_UNI_ERASE) begin
         if (sec >= 3'd3) begin
            uni_set = 7'h78;
            hw_block = !top_boot_guard_n;
         end else begin
            uni_set = 7'h01 << sec;
            hw_block = !write_guard_n;
         end
      end else if (sec == 3'd6) begin
         uni_set = 7'h40;
         hw_block = !top_boot_guard_n;
      end else begin
         uni_set = 7'h01 << sec;
         hw_block = !write_guard_n;
      end
      for (int i = 0; i < NUM_SECTORS; i++) begin
         if (uni_set[i] && lock_q[i][`LOCK_WR_BIT]) begin
            sw_block = 1'b1;
         end
      end
   end

   // Decision is taken only at start, so later pin or lock changes wait
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
         op_allow <= 1'b0;
         op_refused <= 1'b0;
      end else begin
         op_refused <= 1'b0;
         op_allow <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (op_start && kind != OP_NONE) begin
                  if (hw_block || sw_block) begin
                     op_refused <= 1'b1;
                  end else begin
                     op_allow <= 1'b1;
                     state_q <= ST_BUSY;
                  end
               end
            end
            ST_BUSY: begin
               if (op_done) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
   assign op_busy = (state_q == ST_BUSY);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lock_error <= 1'b0;
      end else if (state_q == ST_IDLE && op_start && kind != OP_NONE && sw_block) begin
         lock_error <= 1'b1;
      end else if (op_start && kind != OP_NONE && state_q == ST_IDLE) begin
         lock_error <= 1'b0;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_top_guard;
      @(posedge clk) disable iff (sys_rst)
      (state_q == ST_IDLE && op_start && kind != OP_NONE && sec == 3'd6 && !top_boot_guard_n)
      |=> op_refused && !op_allow;
   endproperty
   a_top_guard: assert property (p_top_guard) else $error("Top sector op not refused");

   property p_uni_top;
      @(posedge clk) disable iff (sys_rst)
      (state_q == ST_IDLE && op_start && kind == OP_UNI_ERASE && sec == 3'd3 && !top_boot_guard_n)
      |=> op_refused;
   endproperty
   a_uni_top: assert property (p_uni_top) else $error("Uniform erase of top not refused");

   property p_wp_guard;
      @(posedge clk) disable iff (sys_rst)
      (state_q == ST_IDLE && op_start && kind == OP_PROG && sec < 3'd6 && !write_guard_n)
      |=> op_refused;
   endproperty
   a_wp_guard: assert property (p_wp_guard) else $error("Guarded program not refused");

   property p_uni_wp_free;
      @(posedge clk) disable iff (sys_rst)
      (state_q == ST_IDLE && op_start && kind == OP_UNI_ERASE && sec == 3'd4 && !write_guard_n
       && top_boot_guard_n && !sw_block) |=> op_allow;
   endproperty
   a_uni_wp_free: assert property (p_uni_wp_free) else $error("Uniform erase wrongly blocked");

   property p_wlock;
      @(posedge clk) disable iff (sys_rst)
      (state_q == ST_IDLE && op_start && kind == OP_PROG && lock_q[sec][`LOCK_WR_BIT])
      |=> op_refused && lock_error;
   endproperty
   a_wlock: assert property (p_wlock) else $error("Write-locked op not flagged");

   property p_busy_hold;
      @(posedge clk) disable iff (sys_rst)
      op_busy && !op_done |=> op_busy && !op_refused && !op_allow;
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("Op decided while busy");

   property p_lockdown;
      @(posedge clk) disable iff (sys_rst)
      lock_q[3][`LOCK_DN_BIT] |=> $stable(lock_q[3]);
   endproperty
   a_lockdown: assert property (p_lockdown) else $error("Locked-down register changed");

   property p_rdlock;
      @(posedge clk) disable iff (sys_rst)
      arr_rd && lock_q[addr_to_sector(arr_addr)][`LOCK_RD_BIT] |=> rd_data == 8'h00;
   endproperty
   a_rdlock: assert property (p_rdlock) else $error("Read-locked data leaked");

   property p_reset_val;
      @(posedge clk) sys_rst |=> lock_q[6] == 3'h1 && lock_q[0] == 3'h1;
   endproperty
   a_reset_val: assert property (p_reset_val) else $error("Reset value wrong");

   property p_reserved;
      @(posedge clk) disable iff (sys_rst)
      reg_rdata[7:3] == 5'h00;
   endproperty
   a_reserved: assert property (p_reserved) else $error("Reserved bits nonzero");
endmodule

/* File: verif/host_bus_model.sv */
// Purpose: host bus controller model for the lock registers
// Assumes: one-cycle strobes launched 1 ns after rising clk
// Notes: address and data are inverted once released, so stale values never pass
`include "flash_sector_protection_defs.svh"

module host_bus_model (
   input wire logic clk,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_hit,
   output logic reg_wr,
   output logic reg_rd,
   output logic [31:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic hub_mode
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] hub_addr [8] = '{`REG_HUB_S0, `REG_HUB_S1, `REG_HUB_S2, `REG_HUB_S3,
      `REG_HUB_S4, `REG_HUB_S5, `REG_HUB_S6, 32'hFFBC0100};

   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 32'h00000000;
      reg_wdata = 8'h00;
      hub_mode = 1'b1;
   end

   // Index 7 is an unmapped address
   task automatic access(input logic wr, input int s, input logic hub,
      input logic [7:0] wd, output logic [7:0] rd, output logic hit);
      @(posedge clk);
      #1;
      hub_mode = hub;
      reg_addr = hub ? hub_addr[s] : hub_addr[s] ^ `REG_LPC_XOR;
      reg_wdata = wd;
      reg_wr = wr;
      reg_rd = !wr;
      @(posedge clk);
      // Decode is combinational on the address, settled since launch
      hit = reg_hit;
      #1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      rd = reg_rdata;
      reg_addr = ~reg_addr;
      reg_wdata = ~wd;
   endtask
endmodule

/* File: verif/tb_top.sv */
// Purpose: self-checking bench for the sector protection logic
// Assumes: inputs driven 1 ns after rising clk
// Notes: guard pins and write locks are held steady while an operation runs
`include "flash_sector_protection_defs.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, sys_rst, top_boot_guard_n, write_guard_n, op_start, op_done, arr_rd;
   logic [7:0] op_cmd, arr_data, rd_data, reg_rdata, reg_wdata, rv;
   logic [23:0] op_addr, arr_addr;
   logic [31:0] reg_addr;
   logic reg_wr, reg_rd, hub_mode, reg_hit, op_allow, op_refused, lock_error, op_busy;
   logic [7:0] cmds [4] = '{`CMD_PROG_A, `CMD_PROG_B, `CMD_SEC_ERASE, `CMD_UNI_ERASE};
   logic [23:0] base [7] = '{24'h000000, `SEC1_BASE, `SEC2_BASE, `SEC3_BASE,
      `SEC4_BASE, `SEC5_BASE, `SEC6_BASE};
   logic prot;
   logic hv;
   int fails = 0;
   int compares = 0;

   flash_sector_protection uut (.clk(clk), .sys_rst(sys_rst),
      .top_boot_guard_n(top_boot_guard_n), .write_guard_n(write_guard_n),
      .hub_mode(hub_mode), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
      .op_start(op_start), .op_cmd(op_cmd), .op_addr(op_addr), .op_done(op_done),
      .op_allow(op_allow), .op_refused(op_refused), .lock_error(lock_error),
      .op_busy(op_busy), .arr_rd(arr_rd), .arr_addr(arr_addr), .arr_data(arr_data),
      .rd_data(rd_data));
   host_bus_model host (.clk(clk), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .hub_mode(hub_mode));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input int s, input logic hub, input logic [7:0] d);
      host.access(1'b1, s, hub, d, rv, hv);
   endtask

   task automatic rd(input int s, input logic hub, input logic [7:0] exp);
      host.access(1'b0, s, hub, 8'h00, rv, hv);
      chk(rv, exp);
      chk({7'h00, hv}, {7'h00, s < 7});
   endtask

   task automatic op(input logic [7:0] cmd, input int s, input logic al, input logic er);
      @(posedge clk);
      #1;
      op_cmd = cmd;
      op_addr = base[s] + 24'h000010;
      op_start = 1'b1;
      @(posedge clk);
      #1;
      op_start = 1'b0;
      chk({6'h00, op_allow, op_refused}, {6'h00, al, !al});
      chk({7'h00, lock_error}, {7'h00, er});
      if (al) begin
         op_done = 1'b1;
         @(posedge clk);
         #1;
         op_done = 1'b0;
         @(posedge clk);
         #1;
         chk({7'h00, op_busy}, 8'h00);
      end
   endtask

   task automatic ard(input int s, input logic [7:0] exp);
      @(posedge clk);
      #1;
      arr_rd = 1'b1;
      arr_addr = base[s] + 24'h000020;
      arr_data = 8'hA5;
      @(posedge clk);
      #1;
      arr_rd = 1'b0;
      arr_data = 8'h5A;
      chk(rd_data, exp);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs;
      for (int s = 0; s < 7; s++) begin
         rd(s, 1'b1, `LOCK_RESET);
         rd(s, 1'b0, `LOCK_RESET);
         wr(s, s[0], 8'hF8);
         rd(s, 1'b1, 8'h00);
      end
      rd(7, 1'b1, 8'h00);
   endtask

   task automatic t_pins;
      for (int s = 0; s < 7; s++) begin
         for (int c = 0; c < 4; c++) begin
            for (int p = 0; p < 4; p++) begin
               top_boot_guard_n = p[1];
               write_guard_n = p[0];
               prot = (c == 3) ? ((s >= 3) ? !p[1] : !p[0]) : ((s == 6) ? !p[1] : !p[0]);
               op(cmds[c], s, !prot, 1'b0);
            end
         end
         rd(s, 1'b1, 8'h00);
      end
   endtask

   task automatic t_wlock;
      wr(2, 1'b1, 8'h01);
      op(`CMD_PROG_A, 2, 1'b0, 1'b1);
      op(`CMD_UNI_ERASE, 0, 1'b1, 1'b0);
      wr(6, 1'b1, 8'h01);
      op(`CMD_UNI_ERASE, 4, 1'b0, 1'b1);
      wr(6, 1'b1, 8'h00);
      wr(2, 1'b1, 8'h00);
   endtask

   // Start held high while busy must be ignored
   task automatic t_sample;
      op(`CMD_SEC_ERASE, 5, 1'b1, 1'b0);
      @(posedge clk);
      #1;
      op_cmd = `CMD_PROG_B;
      op_addr = base[5];
      op_start = 1'b1;
      @(posedge clk);
      #1;
      chk({5'h00, op_allow, op_refused, op_busy}, 8'h05);
      repeat (3) begin
         @(posedge clk);
         #1;
         chk({5'h00, op_allow, op_refused, op_busy}, 8'h01);
      end
      op_start = 1'b0;
      op_done = 1'b1;
      @(posedge clk);
      #1;
      op_done = 1'b0;
      write_guard_n = 1'b0;
      @(posedge clk);
      #1;
      chk({7'h00, op_busy}, 8'h00);
      op(`CMD_PROG_A, 5, 1'b0, 1'b0);
      // Unknown command codes must be neither accepted nor refused
      @(posedge clk);
      #1;
      op_cmd = 8'h00;
      op_start = 1'b1;
      @(posedge clk);
      #1;
      op_start = 1'b0;
      chk({5'h00, op_allow, op_refused, op_busy}, 8'h00);
   endtask

   task automatic t_read;
      wr(1, 1'b1, 8'h04);
      ard(1, `READ_LOCKED_DATA);
      chk({7'h00, lock_error}, 8'h00);
      rd(1, 1'b0, 8'h04);
      wr(1, 1'b1, 8'h00);
      ard(1, 8'hA5);
      write_guard_n = 1'b1;
   endtask

   task automatic t_down;
      wr(3, 1'b1, 8'h03);
      wr(3, 1'b0, 8'h00);
      rd(3, 1'b1, 8'h03);
      wr(3, 1'b1, 8'h07);
      rd(3, 1'b1, 8'h03);
      sys_rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      rd(3, 1'b1, `LOCK_RESET);
   endtask

   task automatic final_report;
      if (fails == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Whole run needs well under 60 us
   initial begin
      #400000;
      fails++;
      final_report();
   end

   initial begin
      sys_rst = 1'b1;
      top_boot_guard_n = 1'b1;
      write_guard_n = 1'b1;
      op_start = 1'b0;
      op_cmd = 8'h00;
      op_addr = 24'h000000;
      op_done = 1'b0;
      arr_rd = 1'b0;
      arr_addr = 24'h000000;
      arr_data = 8'h00;
      repeat (16) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      t_regs();
      t_pins();
      top_boot_guard_n = 1'b1;
      write_guard_n = 1'b1;
      t_wlock();
      t_sample();
      t_read();
      t_down();
      final_report();
   end
endmodule
